// ==== cdi_pkg.sv ====
// Shared constants and types for the coherent DMA invalidate link
`default_nettype none
package cdi_pkg;
  // ****************************************************************
  // Address field layout
  // ****************************************************************
  localparam int AD_LO_POS   = 4;
  localparam int AD_HI_POS   = 12;
  localparam int WSEL_W      = 2;
  localparam int INV_ADDR_W  = AD_HI_POS - AD_LO_POS + 1 + WSEL_W;
  localparam int AD_W        = 32;
  localparam int MODE_BIT    = 5;
  localparam int MODE_W      = 6;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [INV_ADDR_W-1:0] INV_ADDR_RST = 11'h000;
  localparam logic                  SNOOP_EN_RST = 1'b0;
  // Device arbitration states
  typedef enum logic [2:0] {
    CDI_IDLE, CDI_FINISH, CDI_DRAIN_RD, CDI_FLUSH_WR, CDI_GRANTED
  } cdi_arb_type;
  // Master states
  typedef enum logic [2:0] {
    CDI_M_IDLE, CDI_M_WAIT, CDI_M_ADDR, CDI_M_DATA, CDI_M_END, CDI_M_REL
  } cdi_mst_type;
endpackage
`default_nettype wire

// ==== cdi_link_if.sv ====
// Link between the processor bus interface and the external DMA master
`timescale 1ns/1ps
`default_nettype none
interface cdi_link_if;
  logic              bus_request;
  logic              coherent_request;
  logic              bus_grant;
  logic              address_latch_strobe;
  logic              write_strobe;
  logic              transfer_ack;
  logic              invalidate_request;
  logic [31:0]       muxed_addr_data;
  logic [1:0]        low_word_select;
  logic              cpu_drive_oe;
  modport device (
    input  bus_request, coherent_request, address_latch_strobe, write_strobe,
    input  transfer_ack, invalidate_request, muxed_addr_data, low_word_select,
    output bus_grant, cpu_drive_oe
  );
  modport master (
    output bus_request, coherent_request, address_latch_strobe, write_strobe,
    output muxed_addr_data, low_word_select,
    input  bus_grant, transfer_ack, invalidate_request, cpu_drive_oe
  );
endinterface
`default_nettype wire

// ==== cdi_device.sv ====
// Processor-side coherent DMA arbitration and invalidate logic
//
// Contract
// - master raises coherent request with bus request
// - finish bus cycle, then make memory current
// - drain read buffer into cache first
// - stall core, retire writes, no new reads
// - grant only when drained, current and stalled
// - master holds coherent request stable throughout
// - invalidate address from bits 12:4, 3:2
// - latch strobe plus write loads counter
// - memory raises invalidate with transfer ack
// - invalidate word at current counter value
// - every ack increments; invalidate uses old
// - burst: one address, one ack per word
// - one invalidate per cycle, two-cycle writes
// - master drops write strobe after each write; this master holds it across the burst and drops it after the last word
// - enable latched from mode pin 5 at reset
// - sample invalidate only under all four conditions
// - drop grant on falling edge after release
`timescale 1ns/1ps
`default_nettype none
module cdi_device
  import cdi_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  cdi_link_if.device                 link,
  input  wire logic [MODE_W-1:0]     mode_vector_pin,
  input  wire logic                  bus_cycle_busy,
  input  wire logic                  read_buffer_pending,
  input  wire logic                  write_pending,
  output logic                       read_buffer_drain,
  output logic                       core_stall,
  output logic                       cache_inv_valid,
  output logic [INV_ADDR_W-1:0]      cache_inv_addr,
  output logic                       snoop_invalidate_enable
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [AD_HI_POS-AD_LO_POS+WSEL_W:0] addr1_q;
  logic [AD_HI_POS-AD_LO_POS+WSEL_W:0] addr2_q;
  logic [MODE_W-1:0] mode1_q;
  logic [MODE_W-1:0] mode2_q;
  logic breq, creq, ale, wr, ack, ivd;

  // Two stages on every link pin before any logic looks at it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      addr1_q <= INV_ADDR_RST;
      addr2_q <= INV_ADDR_RST;
    end else begin
      sync1_q <= {link.bus_request, link.coherent_request, link.address_latch_strobe,
                  link.write_strobe, link.transfer_ack, link.invalidate_request};
      sync2_q <= sync1_q;
      addr1_q <= {link.muxed_addr_data[AD_HI_POS:AD_LO_POS], link.low_word_select};
      addr2_q <= addr1_q;
    end
  end

  // Mode pin stages carry no reset, so the level is through both when reset ends
  always_ff @(posedge clock) begin
    mode1_q <= mode_vector_pin;
    mode2_q <= mode1_q;
  end
  assign breq = sync2_q[5];
  assign creq = sync2_q[4];
  assign ale  = sync2_q[3];
  assign wr   = sync2_q[2];
  assign ack  = sync2_q[1];
  assign ivd  = sync2_q[0];

  // ****************************************************************
  // Mode capture after reset release
  // ****************************************************************
  logic mode_taken_q;

  // Captured on the first clock after release; pin low enables snooping
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_taken_q            <= 1'b0;
      snoop_invalidate_enable <= SNOOP_EN_RST;
    end else if (!mode_taken_q) begin
      mode_taken_q            <= 1'b1;
      snoop_invalidate_enable <= ~mode2_q[MODE_BIT];
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  cdi_arb_type arb_q;
  logic        coh_q;

  // Coherent requests housekeep before grant; plain ones only wait
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arb_q <= CDI_IDLE;
      coh_q <= 1'b0;
    end else begin
      case (arb_q)
        CDI_IDLE: begin
          if (breq && mode_taken_q) begin
            coh_q <= creq && snoop_invalidate_enable;
            arb_q <= CDI_FINISH;
          end
        end
        CDI_FINISH: begin
          if (!breq) begin
            arb_q <= CDI_IDLE;
          end else if (!bus_cycle_busy) begin
            arb_q <= coh_q ? CDI_DRAIN_RD : CDI_GRANTED;
          end
        end
        CDI_DRAIN_RD: begin
          if (!read_buffer_pending) begin
            arb_q <= CDI_FLUSH_WR;
          end
        end
        CDI_FLUSH_WR: begin
          // Streaming may add writes; wait until none remain
          if (!write_pending && !read_buffer_pending) begin
            arb_q <= CDI_GRANTED;
          end
        end
        CDI_GRANTED: begin
          if (!breq) begin
            arb_q <= CDI_IDLE;
            coh_q <= 1'b0;
          end
        end
        default: arb_q <= CDI_IDLE;
      endcase
    end
  end

  // Drain and stall lines, registered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      read_buffer_drain <= 1'b0;
      core_stall        <= 1'b0;
    end else begin
      read_buffer_drain <= (arb_q == CDI_DRAIN_RD);
      core_stall        <= coh_q && (arb_q == CDI_FLUSH_WR || arb_q == CDI_GRANTED);
    end
  end

  // Grant rises on rising edge, drops on falling edge after release
  logic grant_rise_q;
  logic grant_fall_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      grant_rise_q <= 1'b0;
    end else begin
      grant_rise_q <= (arb_q == CDI_GRANTED) && breq;
    end
  end
  always_ff @(negedge clock or negedge rst_b) begin
    if (!rst_b) begin
      grant_fall_q <= 1'b0;
    end else begin
      grant_fall_q <= grant_rise_q;
    end
  end
  // Rises with the rising-edge flop, held until the falling-edge copy drops
  assign link.bus_grant    = grant_rise_q | grant_fall_q;
  assign link.cpu_drive_oe = ~(grant_rise_q | grant_fall_q);

  // ****************************************************************
  // Invalidate address counter
  // ****************************************************************
  logic active;
  logic [INV_ADDR_W-1:0] cnt_q;
  assign active = coh_q && (arb_q == CDI_GRANTED) && snoop_invalidate_enable;

  function automatic logic [INV_ADDR_W-1:0] next_word(input logic [INV_ADDR_W-1:0] a);
    next_word = a + 11'h001;
  endfunction

  // Load on strobe+write; each ack steps one word
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= INV_ADDR_RST;
    end else if (active && ale && wr) begin
      cnt_q <= addr2_q;
    end else if (active && wr && ack) begin
      cnt_q <= next_word(cnt_q);
    end
  end

  // Invalidate uses counter before the step, one per cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cache_inv_valid <= 1'b0;
      cache_inv_addr  <= INV_ADDR_RST;
    end else begin
      cache_inv_valid <= active && wr && ack && ivd;
      cache_inv_addr  <= cnt_q;
    end
  end
endmodule
`default_nettype wire

// ==== cdi_master.sv ====
// External DMA master end driving coherent write bursts
`timescale 1ns/1ps
`default_nettype none
module cdi_master
  import cdi_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_b,
  cdi_link_if.master              link,
  input  wire logic               start,
  input  wire logic               coherent,
  input  wire logic [31:0]        start_addr,
  input  wire logic [7:0]         word_count,
  output logic                    busy,
  output logic                    done
);
  cdi_mst_type st_q;
  logic [7:0]  left_q;
  logic        g1_q, g2_q;

  // Grant passes two stages
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      g1_q <= 1'b0;
      g2_q <= 1'b0;
    end else begin
      g1_q <= link.bus_grant;
      g2_q <= g1_q;
    end
  end

  // Request, one address cycle, data words, drop write, release
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q                      <= CDI_M_IDLE;
      left_q                    <= 8'h00;
      busy                      <= 1'b0;
      done                      <= 1'b0;
      link.bus_request          <= 1'b0;
      link.coherent_request     <= 1'b0;
      link.address_latch_strobe <= 1'b0;
      link.write_strobe         <= 1'b0;
      link.muxed_addr_data      <= 32'h0000_0000;
      link.low_word_select      <= 2'h0;
    end else begin
      done <= 1'b0;
      case (st_q)
        CDI_M_IDLE: begin
          if (start && word_count != 8'h00) begin
            link.bus_request      <= 1'b1;
            link.coherent_request <= coherent;
            link.muxed_addr_data  <= start_addr;
            link.low_word_select  <= start_addr[3:2];
            left_q                <= word_count;
            busy                  <= 1'b1;
            st_q                  <= CDI_M_WAIT;
          end
        end
        CDI_M_WAIT: begin
          if (g2_q) begin
            link.address_latch_strobe <= 1'b1;
            link.write_strobe         <= 1'b1;
            st_q                      <= CDI_M_ADDR;
          end
        end
        CDI_M_ADDR: begin
          // Hold address long enough to pass the device synchroniser
          link.address_latch_strobe <= 1'b0;
          st_q                      <= CDI_M_DATA;
        end
        CDI_M_DATA: begin
          if (link.transfer_ack) begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              link.write_strobe <= 1'b0;
              st_q              <= CDI_M_END;
            end
          end
        end
        CDI_M_END: begin
          link.bus_request <= 1'b0;
          st_q             <= CDI_M_REL;
        end
        CDI_M_REL: begin
          if (!g2_q) begin
            link.coherent_request <= 1'b0;
            busy                  <= 1'b0;
            done                  <= 1'b1;
            st_q                  <= CDI_M_IDLE;
          end
        end
        default: st_q <= CDI_M_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== cdi_link_chk.sv ====
// Assertions watching the coherent DMA link between both ends
`timescale 1ns/1ps
`default_nettype none
module cdi_link_chk
  import cdi_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst_b,
  input wire logic                  bus_request,
  input wire logic                  coherent_request,
  input wire logic                  bus_grant,
  input wire logic                  write_strobe,
  input wire logic                  transfer_ack,
  input wire logic                  invalidate_request,
  input wire logic                  cpu_drive_oe,
  input wire logic                  core_stall,
  input wire logic                  cache_inv_valid,
  input wire logic [INV_ADDR_W-1:0] cache_inv_addr,
  input wire logic                  snoop_invalidate_enable
);
  // ****************************************************************
  // Link properties
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Grant is only a reply to a live request
  chk_grant_has_req: assert property ($rose(bus_grant) |-> bus_request)
    else $error("grant rose without a bus request");
  chk_grant_oe_off: assert property ($rose(bus_grant) |-> !cpu_drive_oe)
    else $error("cpu drivers still on at grant");
  chk_grant_release: assert property ($fell(bus_request) |-> ##[1:5] !bus_grant)
    else $error("grant held after request dropped");
  // Coherent grant only with the core held
  chk_coh_stall: assert property (
    bus_grant && coherent_request && snoop_invalidate_enable |-> core_stall)
    else $error("coherent grant without core stall");
  chk_off_no_inv: assert property (!snoop_invalidate_enable |-> !cache_inv_valid)
    else $error("invalidate while coherent mode off");
  // Invalidate strictly three edges after ack with request
  chk_inv_cause: assert property (
    cache_inv_valid |-> $past(transfer_ack & invalidate_request & write_strobe, 3))
    else $error("invalidate without a qualified request");
  chk_inv_follows: assert property (transfer_ack && invalidate_request && write_strobe
    && bus_grant && coherent_request && snoop_invalidate_enable |-> ##3 cache_inv_valid)
    else $error("requested invalidate missing");
  chk_addr_step: assert property (
    cache_inv_valid ##1 cache_inv_valid |-> cache_inv_addr == $past(cache_inv_addr) + 1'b1)
    else $error("invalidate address did not step by one word");
  chk_coh_stable: assert property (bus_request && $past(bus_request) |-> $stable(coherent_request))
    else $error("coherent request changed during mastership");

  cover property ($rose(bus_grant) && coherent_request);
  cover property (cache_inv_valid ##1 cache_inv_valid);
  cover property ($fell(bus_grant));
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench joining device and DMA master ends
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cdi_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic                  clock     = 1'b0;
  logic                  rst_b     = 1'b0;
  logic [MODE_W-1:0]     mode_pin  = 6'h00;
  logic                  cyc_busy  = 1'b0;
  logic                  rd_pend   = 1'b0;
  logic                  wr_pend   = 1'b0;
  logic                  start     = 1'b0;
  logic                  coh       = 1'b0;
  logic [31:0]           saddr     = 32'h0000_0000;
  logic [7:0]            wcnt      = 8'h01;
  logic                  en_exp    = 1'b1;
  logic                  rbd, stall, inv_v, sen, m_busy, m_done;
  logic [INV_ADDR_W-1:0] inv_a;
  logic [INV_ADDR_W-1:0] expq[$];
  int                    n_errors  = 0;
  int                    cmp_count = 0;
  int                    idx       = 0;
  cdi_link_if link();

  always #12.5 clock = ~clock;

  cdi_device u_cdi_device (.clock(clock), .rst_b(rst_b), .link(link),
    .mode_vector_pin(mode_pin), .bus_cycle_busy(cyc_busy), .read_buffer_pending(rd_pend),
    .write_pending(wr_pend), .read_buffer_drain(rbd), .core_stall(stall),
    .cache_inv_valid(inv_v), .cache_inv_addr(inv_a), .snoop_invalidate_enable(sen));
  cdi_master u_cdi_master (.clock(clock), .rst_b(rst_b), .link(link), .start(start),
    .coherent(coh), .start_addr(saddr), .word_count(wcnt), .busy(m_busy), .done(m_done));
  cdi_link_chk u_cdi_link_chk (.clock(clock), .rst_b(rst_b),
    .bus_request(link.bus_request), .coherent_request(link.coherent_request),
    .bus_grant(link.bus_grant), .write_strobe(link.write_strobe),
    .transfer_ack(link.transfer_ack), .invalidate_request(link.invalidate_request),
    .cpu_drive_oe(link.cpu_drive_oe), .core_stall(stall), .cache_inv_valid(inv_v),
    .cache_inv_addr(inv_a), .snoop_invalidate_enable(sen));

  // Memory side: ack each data word, skip invalidate on the second word
  always @(posedge clock) begin
    if (link.address_latch_strobe && link.write_strobe) begin
      idx = 0;
    end else if (link.transfer_ack && link.write_strobe) begin
      if (link.invalidate_request && coh && en_exp) begin
        expq.push_back({saddr[12:4], saddr[3:2]} + 11'(idx));
      end
      idx++;
    end
    link.transfer_ack <= link.write_strobe && !link.address_latch_strobe;
    link.invalidate_request <= link.write_strobe && !link.address_latch_strobe && idx != 1;
  end

  // Every invalidate must match the next expected word
  always @(posedge clock) begin
    if (inv_v === 1'b1) begin
      if (expq.size() == 0) chk("inv_extra", 11'h000, 11'h001);
      else chk("inv_addr", expq.pop_front(), inv_a);
    end
  end

  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Sample at the falling edge, away from the launching edge
  task automatic waitn(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic do_reset(input logic m5);
    @(posedge clock);
    rst_b    <= 1'b0;
    mode_pin <= {m5, 5'h00};
    en_exp   = !m5;
    waitn(1);
    chk("oe_in_reset", 11'h001, 11'(link.cpu_drive_oe));
    @(posedge clock) rst_b <= 1'b1;
    waitn(4);
    chk("snoop_en", 11'(!m5), 11'(sen));
  endtask

  task automatic kick(input logic c, input logic [31:0] a, input logic [7:0] n);
    @(posedge clock);
    coh   <= c;
    saddr <= a;
    wcnt  <= n;
    start <= 1'b1;
    @(posedge clock) start <= 1'b0;
  endtask

  // Bounded wait for the master to finish, then check nothing is left over
  task automatic finish_run(input string nm);
    int i;
    for (i = 0; i < 400 && m_done !== 1'b1; i++) @(negedge clock);
    if (m_done !== 1'b1) begin
      n_errors++;
      $display("Error %s expected done seen timeout", nm);
      print_verdict();
    end else begin
      waitn(8);
      chk("grant_off", 11'h000, 11'(link.bus_grant));
      chk("queue_left", 11'h000, 11'(expq.size()));
      chk("busy_off", 11'h000, 11'(m_busy));
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    do_reset(1'b0);
    // Coherent burst, housekeeping released stage by stage, address carries
    cyc_busy <= 1'b1;
    rd_pend  <= 1'b1;
    wr_pend  <= 1'b1;
    kick(1'b1, 32'h0000_1FF8, 8'h04);
    waitn(15);
    chk("drain_busy", 11'h000, 11'(rbd));
    chk("grant_busy", 11'h000, 11'(link.bus_grant));
    @(posedge clock) cyc_busy <= 1'b0;
    waitn(15);
    chk("drain", 11'h001, 11'(rbd));
    chk("grant_rd", 11'h000, 11'(link.bus_grant));
    @(posedge clock) rd_pend <= 1'b0;
    waitn(15);
    chk("stall", 11'h001, 11'(stall));
    chk("grant_wr", 11'h000, 11'(link.bus_grant));
    @(posedge clock) wr_pend <= 1'b0;
    finish_run("burst");
    kick(1'b1, 32'h0000_0104, 8'h01);
    finish_run("single");
    // Plain DMA is granted without waiting on housekeeping
    rd_pend <= 1'b1;
    wr_pend <= 1'b1;
    kick(1'b0, 32'h0000_0200, 8'h02);
    finish_run("plain");
    // Coherent mode off: coherent request treated as plain
    do_reset(1'b1);
    kick(1'b1, 32'h0000_0300, 8'h03);
    finish_run("disabled");
    print_verdict();
  end

  // Hang guard
  initial begin
    #500000;
    n_errors++;
    $display("Error run expected finish seen timeout");
    print_verdict();
  end
endmodule
`default_nettype wire
